// ==== hdl/part_timer.sv ====
// Operation
// - Counter increments on each prescaler output tick.
// - Overflow reloads auto-reload value, prescaler untouched.
// - Counter readable and writable while it runs.
// - Prescaler divides by two to prescale_select.
// - ext_clk_select picks CPU or external clock.
// - count_enable low freezes prescaler and counter.
// - Reset clears counter, prescaler, selects CPU clock.
// - Force reload with enable loads auto-reload value.
// - Counter initialisation also clears the prescaler.
// - Compare shadows reload from duty at overflow.
// - Output enable drives each PWM pin independently.
// - Shared period is 256 minus auto-reload value.
// - Overflow sets polarity level, compare restores opposite.
// - PWM generation halts in halt mode.
// - Overflow sets flag, requests irq if enabled.
// - Reading control/status clears the overflow flag.
// - External events count 256 minus reload value.
// - Capture edge latches counter, sets flag, irq.
// - Edge select zero falling, one rising.
// - Capture blocked until read; irq stays pending.
// - Reading capture value clears its flag.
// - Capture input synchronised; latches next count.
// - Halt blocks capture; enabled edge still wakes.
// - Capture inputs double as external interrupts.
// - Force reload bit always reads zero.
//
// Implementation choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module part_timer (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [part_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // System and pins
  input wire logic halt_i,
  input wire logic external_clock_input_i,
  input wire logic [part_pkg::NUM_CAP-1:0] capture_input_pin_i,
  output logic [part_pkg::NUM_PWM-1:0] pwm_out_pin_o,
  output logic [part_pkg::NUM_PWM-1:0] pwm_out_pin_oe_o,
  // Requests
  output logic ovf_irq_o,
  output logic [part_pkg::NUM_CAP-1:0] cap_irq_o,
  output logic wake_o
);
  import part_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [PSC_W-1:0] psc;
    logic [CNT_W-1:0] arr;
    logic [NUM_PWM-1:0][CNT_W-1:0] duty;
    logic [NUM_PWM-1:0][CNT_W-1:0] ocr;
    logic [7:0] pwmc;
    logic ext_clk_select;
    logic [2:0] cc;
    logic count_enable;
    logic overflow_irq_enable;
    logic ovf;
    logic [NUM_CAP-1:0] cs;
    logic [NUM_CAP-1:0] cie;
    logic [2:0] ext_sync;
    logic ext_lvl;
    logic [NUM_PWM-1:0] pwm;
    logic [NUM_PWM-1:0] oe;
    logic ovf_irq;
    logic [NUM_CAP-1:0] cap_irq;
    logic wake;
    logic ack;
    logic [31:0] dat;
  } part_state_t;

  part_state_t st_ff;
  part_state_t nxt_st;

  logic req;
  logic wr;
  logic rd;
  logic [5:0] idx;
  logic ext_rise;
  logic in_tick;
  logic run;
  logic [PSC_W-1:0] mask;
  logic cnt_tick;
  logic ovf_evt;
  logic [7:0] rdata;
  logic [NUM_CAP-1:0] cap_flag;
  logic [NUM_CAP-1:0][CNT_W-1:0] cap_val;
  logic [NUM_CAP-1:0] cap_edge;
  logic [NUM_CAP-1:0] cap_rd;

  always_comb begin
    nxt_st = st_ff;
    req = wb_cyc_i && wb_stb_i && !st_ff.ack;
    wr = req && wb_we_i && wb_sel_i[0];
    rd = req && !wb_we_i;
    idx = wb_adr_i[7:2];
    rdata = 8'h00;
    ext_rise = 1'b0;
    nxt_st.ack = req;

    // External clock pin: three stages, stages 1 and 2 must agree
    nxt_st.ext_sync = {st_ff.ext_sync[1:0], external_clock_input_i};
    if (st_ff.ext_sync[1] == st_ff.ext_sync[2] &&
        st_ff.ext_sync[2] != st_ff.ext_lvl) begin
      nxt_st.ext_lvl = st_ff.ext_sync[2];
      ext_rise = st_ff.ext_sync[2];
    end

    // Prescaler and counter
    in_tick = st_ff.ext_clk_select ? ext_rise : 1'b1;
    run = st_ff.count_enable && !halt_i && in_tick;
    mask = PSC_W'((8'h01 << st_ff.cc) - 8'h01);
    cnt_tick = run && ((st_ff.psc & mask) == mask);
    ovf_evt = cnt_tick && (st_ff.cnt == CNT_TOP);
    if (run) begin
      nxt_st.psc = st_ff.psc + 7'h01;
    end
    if (cnt_tick) begin
      if (ovf_evt) begin
        nxt_st.cnt = st_ff.arr;
      end else begin
        nxt_st.cnt = st_ff.cnt + 8'h01;
      end
    end
    if (ovf_evt) begin
      nxt_st.ocr = st_ff.duty;
    end

    // Overflow flag: read clears, a new overflow wins
    if (rd && idx == IDX_CSR) begin
      nxt_st.ovf = 1'b0;
    end
    if (ovf_evt) begin
      nxt_st.ovf = 1'b1;
    end

    // Register writes
    if (wr) begin
      case (idx)
        IDX_DUTY0: nxt_st.duty[0] = wb_dat_i[7:0];
        IDX_DUTY1: nxt_st.duty[1] = wb_dat_i[7:0];
        IDX_DUTY2: nxt_st.duty[2] = wb_dat_i[7:0];
        IDX_DUTY3: nxt_st.duty[3] = wb_dat_i[7:0];
        IDX_PWMC: nxt_st.pwmc = wb_dat_i[7:0];
        IDX_CSR: begin
          nxt_st.ext_clk_select = wb_dat_i[CSR_EXT_CLK_SELECT];
          nxt_st.cc = wb_dat_i[CSR_CC_LO +: 3];
          nxt_st.count_enable = wb_dat_i[CSR_TCE];
          nxt_st.overflow_irq_enable = wb_dat_i[CSR_OIE];
          if (wb_dat_i[CSR_FORCE_RELOAD]) begin
            nxt_st.cnt = st_ff.arr;
            nxt_st.psc = PSC_CLEAR;
          end
        end
        IDX_CAR: begin
          nxt_st.cnt = wb_dat_i[7:0];
          nxt_st.psc = PSC_CLEAR;
        end
        IDX_ARR: nxt_st.arr = wb_dat_i[7:0];
        IDX_ICCSR: begin
          nxt_st.cs = wb_dat_i[ICC_CS_LO +: NUM_CAP];
          nxt_st.cie = wb_dat_i[ICC_CIE_LO +: NUM_CAP];
        end
        default: ;
      endcase
    end

    // Register reads; unmapped addresses read zero
    case (idx)
      IDX_DUTY0: rdata = st_ff.duty[0];
      IDX_DUTY1: rdata = st_ff.duty[1];
      IDX_DUTY2: rdata = st_ff.duty[2];
      IDX_DUTY3: rdata = st_ff.duty[3];
      IDX_PWMC: rdata = st_ff.pwmc;
      IDX_CSR: rdata = {st_ff.ext_clk_select, st_ff.cc, st_ff.count_enable, 1'b0,
                        st_ff.overflow_irq_enable, st_ff.ovf};
      IDX_CAR: rdata = st_ff.cnt;
      IDX_ARR: rdata = st_ff.arr;
      IDX_ICCSR: rdata = {2'b00, st_ff.cs, st_ff.cie, cap_flag};
      IDX_ICR1: rdata = cap_val[0];
      IDX_ICR2: rdata = cap_val[1];
      default: rdata = 8'h00;
    endcase
    nxt_st.dat = rd ? {24'h000000, rdata} : 32'h00000000;

    // PWM pins; polarity change takes effect on the next edge
    for (int i = 0; i < NUM_PWM; i++) begin
      nxt_st.oe[i] = st_ff.pwmc[PWMC_OE_LO + i];
      // A disabled channel goes low even in halt; enabled ones hold there
      if (!st_ff.pwmc[PWMC_OE_LO + i]) begin
        nxt_st.pwm[i] = 1'b0;
      end else if (!halt_i) begin
        nxt_st.pwm[i] = (st_ff.cnt <= st_ff.ocr[i]) ^
                        st_ff.pwmc[PWMC_OP_LO + i];
      end
    end

    // Requests
    nxt_st.ovf_irq = nxt_st.ovf && st_ff.overflow_irq_enable;
    nxt_st.cap_irq = cap_flag & st_ff.cie;
    nxt_st.wake = halt_i && |(cap_edge & st_ff.cie);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign cap_rd[0] = rd && idx == IDX_ICR1;
  assign cap_rd[1] = rd && idx == IDX_ICR2;

  // One capture channel per input pin
  for (genvar c = 0; c < NUM_CAP; c++) begin : g_cap
    part_capture u_cap (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pin_i(capture_input_pin_i[c]),
      .edge_sel_i(st_ff.cs[c]),
      .halt_i(halt_i),
      .cnt_val_i(nxt_st.cnt),
      .rd_clr_i(cap_rd[c]),
      .flag_o(cap_flag[c]),
      .value_o(cap_val[c]),
      .edge_o(cap_edge[c])
    );
  end

  assign wb_dat_o = st_ff.dat;
  assign wb_ack_o = st_ff.ack;
  assign pwm_out_pin_o = st_ff.pwm;
  assign pwm_out_pin_oe_o = st_ff.oe;
  assign ovf_irq_o = st_ff.ovf_irq;
  assign cap_irq_o = st_ff.cap_irq;
  assign wake_o = st_ff.wake;

  overflow_reload_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ovf_evt && !wr |=> st_ff.cnt == $past(st_ff.arr) &&
                       st_ff.psc == $past(st_ff.psc) + 7'h01)
    else $error("overflow did not reload counter");
  overflow_flag_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ovf_evt |=> st_ff.ovf ##1 (st_ff.ovf_irq == st_ff.overflow_irq_enable || $past(rd)))
    else $error("overflow flag or request wrong");
  flag_read_clear_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    rd && idx == IDX_CSR && !ovf_evt |=> !st_ff.ovf)
    else $error("reading status left overflow flag set");
  freeze_count_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !st_ff.count_enable && !wr |=> $stable(st_ff.cnt) && $stable(st_ff.psc))
    else $error("counter moved while disabled");
  force_reload_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wr && idx == IDX_CSR && wb_dat_i[CSR_FORCE_RELOAD]
    |=> st_ff.cnt == $past(st_ff.arr) && st_ff.psc == PSC_CLEAR)
    else $error("force reload failed");
  shadow_load_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !ovf_evt |=> $stable(st_ff.ocr))
    else $error("compare shadow changed without overflow");
  cpu_tick_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    st_ff.count_enable && !st_ff.ext_clk_select && st_ff.cc == 3'h0 && !halt_i && !wr &&
    st_ff.cnt != CNT_TOP |=> st_ff.cnt == $past(st_ff.cnt) + 8'h01)
    else $error("undivided counter did not step");
  bus_ack_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single cycle after request");
  pwm_disable_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !st_ff.pwmc[PWMC_OE_LO] |=> !pwm_out_pin_oe_o[0] && !pwm_out_pin_o[0])
    else $error("disabled PWM channel drives");
endmodule // part_timer
`default_nettype wire

// ==== hdl/part_pkg.sv ====
package part_pkg;
  // Channel counts and widths
  localparam int NUM_PWM = 4;
  localparam int NUM_CAP = 2;
  localparam int CNT_W = 8;
  localparam int PSC_W = 7;
  localparam int ADR_W = 8;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_DUTY3 = 6'h31;
  localparam logic [5:0] IDX_DUTY2 = 6'h32;
  localparam logic [5:0] IDX_DUTY1 = 6'h33;
  localparam logic [5:0] IDX_DUTY0 = 6'h34;
  localparam logic [5:0] IDX_PWMC = 6'h35;
  localparam logic [5:0] IDX_CSR = 6'h36;
  localparam logic [5:0] IDX_CAR = 6'h37;
  localparam logic [5:0] IDX_ARR = 6'h38;
  localparam logic [5:0] IDX_ICCSR = 6'h39;
  localparam logic [5:0] IDX_ICR1 = 6'h3A;
  localparam logic [5:0] IDX_ICR2 = 6'h3B;

  // timer_control_status fields
  localparam int CSR_EXT_CLK_SELECT = 7;
  localparam int CSR_CC_LO = 4;
  localparam int CSR_TCE = 3;
  localparam int CSR_FORCE_RELOAD = 2;
  localparam int CSR_OIE = 1;
  localparam int CSR_OVF = 0;

  // pwm_control fields
  localparam int PWMC_OE_LO = 4;
  localparam int PWMC_OP_LO = 0;

  // capture_ctrl_status fields
  localparam int ICC_CS_LO = 4;
  localparam int ICC_CIE_LO = 2;
  localparam int ICC_CF_LO = 0;

  // Reset values and counter limits
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] CNT_TOP = 8'hFF;
  localparam logic [6:0] PSC_CLEAR = 7'h00;
endpackage

// ==== hdl/part_capture.sv ====
`timescale 1ns/1ps
`default_nettype none
module part_capture (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Pin and control
  input wire logic pin_i,
  input wire logic edge_sel_i,
  input wire logic halt_i,
  input wire logic [part_pkg::CNT_W-1:0] cnt_val_i,
  input wire logic rd_clr_i,
  // Status
  output logic flag_o,
  output logic [part_pkg::CNT_W-1:0] value_o,
  output logic edge_o
);
  import part_pkg::*;

  typedef struct packed {
    logic [2:0] sync;
    logic lvl;
    logic flag;
    logic [CNT_W-1:0] value;
    logic edge_hit;
  } part_cap_t;

  part_cap_t st_ff;
  part_cap_t nxt_st;
  logic ev;
  logic take;

  always_comb begin
    nxt_st = st_ff;
    ev = 1'b0;
    // Stage 0 feeds only stage 1; stages 1 and 2 must agree
    nxt_st.sync = {st_ff.sync[1:0], pin_i};
    if (st_ff.sync[1] == st_ff.sync[2] && st_ff.sync[2] != st_ff.lvl) begin
      nxt_st.lvl = st_ff.sync[2];
      ev = (st_ff.sync[2] == edge_sel_i);
    end
    nxt_st.edge_hit = ev;
    // A capture in the same cycle as the clearing read is kept
    take = ev && !halt_i && (!st_ff.flag || rd_clr_i);
    if (rd_clr_i) begin
      nxt_st.flag = 1'b0;
    end
    if (take) begin
      nxt_st.value = cnt_val_i;
      nxt_st.flag = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign flag_o = st_ff.flag;
  assign value_o = st_ff.value;
  assign edge_o = st_ff.edge_hit;

  capture_hold_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    st_ff.flag && !rd_clr_i |=> $stable(st_ff.value) && st_ff.flag)
    else $error("capture value changed while flag pending");
  capture_set_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ev && !halt_i && !st_ff.flag |=> st_ff.flag && st_ff.value == $past(cnt_val_i))
    else $error("selected edge did not capture counter");
  halt_block_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    halt_i |=> $stable(st_ff.value))
    else $error("capture value updated during halt");
endmodule // part_capture
`default_nettype wire

// ==== testbench/tb_part_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_part_timer;
  import part_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [ADR_W-1:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h1;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic halt_i = 1'b0;
  logic ext = 1'b0;
  logic [NUM_CAP-1:0] cap = 2'h0;
  logic [NUM_PWM-1:0] pwm, oe;
  logic ovf, wake;
  logic [NUM_CAP-1:0] cirq;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc_n = 0;
  logic [31:0] q;

  part_timer i_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .halt_i,
    .external_clock_input_i(ext), .capture_input_pin_i(cap),
    .pwm_out_pin_o(pwm), .pwm_out_pin_oe_o(oe), .ovf_irq_o(ovf),
    .cap_irq_o(cirq), .wake_o(wake));

  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) cyc_n <= cyc_n + 1;

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic idle(input int k);
    repeat (k) @(posedge clk_i);
  endtask

  // Classic single cycle; waits for ack under a bound
  task automatic wb(input logic we, input logic [5:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {24'h000000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) chk(32'h1, 32'h0);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic rd_chk(input logic [5:0] idx, input logic [7:0] exp);
    wb(1'b0, idx, 8'h00);
    chk(q, {24'h000000, exp});
  endtask

  task automatic wait_ovf(output int t);
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ovf !== 1'b1 && n < 40000);
    if (n >= 40000) chk(32'h1, 32'h0);
    t = cyc_n;
  endtask

  task automatic pulse(input int k);
    repeat (k) begin
      ext <= 1'b1;
      idle(6);
      ext <= 1'b0;
      idle(6);
    end
  endtask

  task automatic t_reset();
    chk({pwm, oe, ovf, cirq, wake}, 32'h0);
    rd_chk(IDX_CSR, 8'h00);
    rd_chk(IDX_CAR, 8'h00);
    rd_chk(IDX_ARR, 8'h00);
    rd_chk(IDX_ICCSR, 8'h00);
    rd_chk(6'h00, 8'h00);
  endtask

  task automatic t_hold();
    wb(1'b1, IDX_CAR, 8'h55);
    rd_chk(IDX_CAR, 8'h55);
    idle(20);
    rd_chk(IDX_CAR, 8'h55);
  endtask

  // Overflow to overflow spacing for a prescale code
  task automatic t_period(input logic [2:0] cc);
    int t0, t1;
    wb(1'b1, IDX_ARR, 8'h80);
    wb(1'b1, IDX_CSR, {1'b0, cc, 4'hE});
    // Drop a flag left over from the previous run before timing
    wb(1'b0, IDX_CSR, 8'h00);
    wait_ovf(t0);
    rd_chk(IDX_CSR, {1'b0, cc, 4'hB});
    rd_chk(IDX_CSR, {1'b0, cc, 4'hA});
    wait_ovf(t1);
    chk(t1 - t0, 128 << cc);
    rd_chk(IDX_CSR, {1'b0, cc, 4'hB});
  endtask

  task automatic t_ext();
    wb(1'b1, IDX_ARR, 8'hFC);
    wb(1'b1, IDX_CSR, 8'h8C);
    pulse(3);
    rd_chk(IDX_CAR, 8'hFF);
    rd_chk(IDX_CSR, 8'h88);
    pulse(1);
    rd_chk(IDX_CSR, 8'h89);
    rd_chk(IDX_CAR, 8'hFC);
  endtask

  task automatic t_pwm();
    logic [7:0] dc [NUM_PWM] = '{8'h20, 8'h50, 8'h80, 8'hB0};
    int hi [NUM_PWM];
    int i;
    logic [NUM_PWM-1:0] p;
    wb(1'b1, IDX_ARR, 8'h00);
    for (i = 0; i < NUM_PWM; i++) begin
      wb(1'b1, IDX_DUTY0 - 6'(i), dc[i]);
      hi[i] = 0;
    end
    wb(1'b1, IDX_PWMC, 8'hFA);
    wb(1'b1, IDX_CSR, 8'h0C);
    idle(300);
    repeat (256) begin
      @(posedge clk_i);
      for (i = 0; i < NUM_PWM; i++) begin
        hi[i] += (pwm[i] === 1'b1) ? 1 : 0;
      end
    end
    chk(oe, 4'hF);
    for (i = 0; i < NUM_PWM; i++) begin
      chk(hi[i], i[0] ? 255 - dc[i] : dc[i] + 1);
    end
    halt_i <= 1'b1;
    idle(2);
    p = pwm;
    i = 0;
    repeat (200) begin
      @(posedge clk_i);
      i += (pwm !== p) ? 1 : 0;
    end
    chk(i, 0);
    halt_i <= 1'b0;
  endtask

  task automatic t_cap();
    int n;
    wb(1'b1, IDX_CSR, 8'h00);
    wb(1'b1, IDX_CAR, 8'h3C);
    wb(1'b1, IDX_ICCSR, 8'h1C);
    cap[0] <= 1'b1;
    idle(10);
    chk(cirq, 2'b01);
    rd_chk(IDX_ICCSR, 8'h1D);
    wb(1'b1, IDX_CAR, 8'h77);
    cap[0] <= 1'b0;
    idle(10);
    cap[0] <= 1'b1;
    idle(10);
    rd_chk(IDX_ICR1, 8'h3C);
    rd_chk(IDX_ICCSR, 8'h1C);
    cap[1] <= 1'b1;
    idle(10);
    rd_chk(IDX_ICCSR, 8'h1C);
    cap[1] <= 1'b0;
    idle(10);
    chk(cirq, 2'b10);
    rd_chk(IDX_ICR2, 8'h77);
    halt_i <= 1'b1;
    cap[0] <= 1'b0;
    idle(10);
    cap[0] <= 1'b1;
    n = 0;
    repeat (12) begin
      @(posedge clk_i);
      n += (wake === 1'b1) ? 1 : 0;
    end
    chk(n, 1);
    rd_chk(IDX_ICCSR, 8'h1C);
    halt_i <= 1'b0;
  endtask

  initial begin
    idle(60000);
    bad_count++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    finish_test();
  end

  initial begin
    idle(12);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_hold();
    t_period(3'd0);
    t_period(3'd1);
    t_period(3'd7);
    t_ext();
    t_pwm();
    t_cap();
    finish_test();
  end
endmodule // tb_part_timer
`default_nettype wire
